// ---- bench/banked_data_memory_addressing_tb_top.sv ----
// Self-checking bench for the banked data-memory address block.
// Assumes dmem_core_model drives the instruction side.
`timescale 1ns/1ps
`default_nettype none

module banked_data_memory_addressing_tb_top;
  import dmem_pkg::*;

  logic              mclk;
  logic              sys_rst;
  logic              ext_en;
  logic [ADDR_W-1:0] idx_base;
  instr_t            instr;
  logic              instr_valid;
  qphase_t           q_phase;
  logic [ADDR_W-1:0] rd_addr;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] rd_data;
  logic              unimpl;
  logic              flag_upd;
  logic              pcl_wr;
  logic [DATA_W-1:0] pcl_data;
  logic [DATA_W-1:0] bank_ptr;
  logic              core_hang;
  int                failures = 0;
  int                checked = 0;

  banked_data_memory_addressing DUT (.MCLK(mclk), .SYS_RST(sys_rst), .INSTR(instr),
    .INSTR_VALID(instr_valid), .EXT_SET_EN(ext_en), .IDX_BASE(idx_base), .Q_PHASE(q_phase),
    .RD_ADDR(rd_addr), .WR_ADDR(wr_addr), .RD_DATA(rd_data), .UNIMPL(unimpl), .FLAG_UPD(flag_upd),
    .PCL_WR(pcl_wr), .PCL_DATA(pcl_data), .BANK_POINTER(bank_ptr));

  dmem_core_model u_core (.clk(mclk), .q_phase(q_phase), .rd_addr(rd_addr), .wr_addr(wr_addr),
    .rd_data(rd_data), .unimpl(unimpl), .flag_upd(flag_upd), .pcl_wr(pcl_wr), .instr(instr),
    .instr_valid(instr_valid), .hang(core_hang));

  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge core_hang) begin
    failures++;
    summarize();
  end

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic instr_t mk(op_kind_t k, logic a, logic [7:0] o, logic w, logic [7:0] d,
                                logic [11:0] s, logic [11:0] t);
    return '{kind: k, a_bit: a, operand: o, src: s, dst: t, lit: d, wr_en: w, wr_data: d};
  endfunction

  task automatic ld(input logic [7:0] v);
    u_core.issue(mk(OP_LOAD_BANK, 1'b0, 8'h00, 1'b0, v, 12'h000, 12'h000));
  endtask

  task automatic dr(input logic a, input logic [7:0] o, input logic w, input logic [7:0] d);
    u_core.issue(mk(OP_DIRECT, a, o, w, d, 12'h000, 12'h000));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_bank;
    chk("bank_ptr_reset", 12'h000, bank_ptr);
    for (int i = 0; i < 16; i++) begin
      ld(8'ha0 | 8'(i));
      dr(1'b0, 8'he0, 1'b0, 8'h00);
      chk("bank_ptr", 12'(i), bank_ptr);
      chk("bank_ptr_read", 12'(i), u_core.o_rd);
    end
    dr(1'b0, 8'he0, 1'b1, 8'h5b);
    dr(1'b0, 8'he0, 1'b0, 8'h00);
    chk("bank_ptr_store", 12'h00b, bank_ptr);
    chk("bank_ptr_store_read", 12'h00b, u_core.o_rd);
    $display("test bank done");
  endtask

  task automatic t_banked;
    ld(8'h03);
    dr(1'b1, 8'h21, 1'b1, 8'h5a);
    chk("wr_addr", 12'h321, u_core.o_wa);
    dr(1'b1, 8'h21, 1'b0, 8'h00);
    chk("rd_addr", 12'h321, u_core.o_ra);
    chk("rd_data", 12'h05a, u_core.o_rd);
    dr(1'b1, 8'hff, 1'b1, 8'hc3);
    dr(1'b1, 8'hff, 1'b0, 8'h00);
    chk("bank_top", 12'h0c3, u_core.o_rd);
    $display("test banked done");
  endtask

  task automatic t_access;
    dr(1'b0, 8'h5f, 1'b1, 8'ha5);
    chk("acc_lo", 12'h05f, u_core.o_wa);
    dr(1'b0, 8'h60, 1'b0, 8'h00);
    chk("acc_hi", 12'hf60, u_core.o_ra);
    ld(8'h00);
    dr(1'b1, 8'h5f, 1'b0, 8'h00);
    chk("acc_data", 12'h0a5, u_core.o_rd);
    $display("test access done");
  endtask

  task automatic t_unimpl;
    ld(8'h05);
    dr(1'b1, 8'h40, 1'b1, 8'h77);
    chk("flag_wr", 12'h001, u_core.o_fl);
    dr(1'b1, 8'h40, 1'b0, 8'h00);
    chk("unimpl_rd", 12'h000, u_core.o_rd);
    chk("unimpl", 12'h001, u_core.o_un);
    ld(8'h0f);
    dr(1'b1, 8'h37, 1'b0, 8'h00);
    chk("below_special", 12'h001, u_core.o_un);
    dr(1'b1, 8'h38, 1'b1, 8'h4b);
    dr(1'b1, 8'h38, 1'b0, 8'h00);
    chk("special_base", 12'h04b, u_core.o_rd);
    $display("test unimpl done");
  endtask

  task automatic t_move;
    ld(8'h07);
    u_core.issue(mk(OP_MOVE, 1'b1, 8'h00, 1'b0, 8'h00, 12'h321, 12'h123));
    chk("mv_src", 12'h321, u_core.o_ra);
    chk("mv_dst", 12'h123, u_core.o_wa);
    ld(8'h01);
    dr(1'b1, 8'h23, 1'b0, 8'h00);
    chk("mv_data", 12'h05a, u_core.o_rd);
    $display("test move done");
  endtask

  task automatic t_pcl;
    ld(8'h0f);
    dr(1'b1, 8'hf9, 1'b1, 8'h3c);
    chk("pcl_wr", 12'h001, u_core.o_pc);
    ld(8'h00);
    chk("pcl_data", 12'h03c, pcl_data);
    $display("test pcl done");
  endtask

  task automatic t_ext;
    @(negedge mclk);
    ext_en = 1'b1;
    idx_base = 12'h200;
    dr(1'b0, 8'h10, 1'b0, 8'h00);
    chk("ext_lo", 12'h210, u_core.o_ra);
    dr(1'b0, 8'h70, 1'b0, 8'h00);
    chk("ext_hi", 12'hf70, u_core.o_ra);
    @(negedge mclk);
    idx_base = 12'hfff;
    dr(1'b0, 8'h02, 1'b0, 8'h00);
    chk("ext_wrap", 12'h001, u_core.o_ra);
    @(negedge mclk);
    ext_en = 1'b0;
    $display("test ext done");
  endtask

  initial begin
    sys_rst = 1'b1;
    ext_en = 1'b0;
    idx_base = 12'h000;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    t_bank();
    t_banked();
    t_access();
    t_unimpl();
    t_move();
    t_pcl();
    t_ext();
    summarize();
  end

endmodule // banked_data_memory_addressing_tb_top
`default_nettype wire

// ---- bench/dmem_core_model.sv ----
// Core-side model: issues one instruction per Q1 and samples the block.
// Assumes the block's Q_PHASE sequence and Q4 result timing.
`timescale 1ns/1ps
`default_nettype none

module dmem_core_model
  import dmem_pkg::*;
(
  input  wire logic              clk,
  input  wire qphase_t           q_phase,
  input  wire logic [ADDR_W-1:0] rd_addr,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] rd_data,
  input  wire logic              unimpl,
  input  wire logic              flag_upd,
  input  wire logic              pcl_wr,
  output var  instr_t            instr,
  output logic                   instr_valid,
  output logic                   hang
);
  logic [ADDR_W-1:0] o_ra;
  logic [ADDR_W-1:0] o_wa;
  logic [DATA_W-1:0] o_rd;
  logic              o_un;
  logic              o_fl;
  logic              o_pc;

  initial begin
    instr = '0;
    instr.kind = OP_NONE;
    instr_valid = 1'b0;
    hang = 1'b0;
  end

  // ----------------------------------------------------------------
  // Issue and observe
  // ----------------------------------------------------------------
  task automatic issue(input instr_t ins);
    int n;
    n = 0;
    @(negedge clk);
    while (q_phase !== Q1 && n < 16) begin
      @(negedge clk);
      n++;
    end
    if (n >= 16) hang = 1'b1;
    instr = ins;
    instr_valid = 1'b1;
    @(negedge clk);
    // Released bus shows the inverse, so a late capture is caught
    instr = ~ins;
    instr_valid = 1'b0;
    o_ra = rd_addr;
    o_wa = wr_addr;
    @(negedge clk);
    @(negedge clk);
    o_rd = rd_data;
    o_un = unimpl;
    o_fl = flag_upd;
    o_pc = pcl_wr;
  endtask

endmodule // dmem_core_model
`default_nettype wire

// ---- design/banked_data_memory_addressing.sv ----
// Data-memory address generation, bank pointer and access-bank map.
// Assumes the core holds INSTR stable and valid at the Q1 cycle.
`timescale 1ns/1ps
`default_nettype none

module banked_data_memory_addressing
  import dmem_pkg::*;
(
  input  wire logic              MCLK,
  input  wire logic              SYS_RST,
  input  wire instr_t            INSTR,
  input  wire logic              INSTR_VALID,
  input  wire logic              EXT_SET_EN,
  input  wire logic [ADDR_W-1:0] IDX_BASE,
  output qphase_t                Q_PHASE,
  output logic      [ADDR_W-1:0] RD_ADDR,
  output logic      [ADDR_W-1:0] WR_ADDR,
  output logic      [DATA_W-1:0] RD_DATA,
  output logic                   UNIMPL,
  output logic                   FLAG_UPD,
  output logic                   PCL_WR,
  output logic      [DATA_W-1:0] PCL_DATA,
  output logic      [DATA_W-1:0] BANK_POINTER
);

  // ----------------------------------------------------------------
  // Quarter-cycle sequencer
  // ----------------------------------------------------------------

  qphase_t phase_ff;
  qphase_t nxt_phase;

  always_comb begin
    case (phase_ff)
      Q1:      nxt_phase = Q2;
      Q2:      nxt_phase = Q3;
      Q3:      nxt_phase = Q4;
      Q4:      nxt_phase = Q1;
      default: nxt_phase = Q1;
    endcase
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      phase_ff <= Q1;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  assign Q_PHASE = phase_ff;

  // ----------------------------------------------------------------
  // Instruction capture
  // ----------------------------------------------------------------

  instr_t cur_ff;
  logic   valid_ff;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cur_ff   <= '0;
      valid_ff <= 1'b0;
    end else if (phase_ff == Q1) begin
      cur_ff   <= INSTR;
      valid_ff <= INSTR_VALID;
    end
  end

  logic is_direct;
  logic is_move;
  logic is_load;

  assign is_direct = valid_ff && (cur_ff.kind == OP_DIRECT);
  assign is_move   = valid_ff && (cur_ff.kind == OP_MOVE);
  assign is_load   = valid_ff && (cur_ff.kind == OP_LOAD_BANK);

  // ----------------------------------------------------------------
  // Bank pointer
  // ----------------------------------------------------------------

  logic [BANK_W-1:0] bank_ff;

  // ----------------------------------------------------------------
  // Effective address
  // ----------------------------------------------------------------

  logic [ADDR_W-1:0] direct_addr;
  logic [ADDR_W-1:0] rd_addr;
  logic [ADDR_W-1:0] wr_addr;

  always_comb begin
    if (cur_ff.a_bit) begin
      direct_addr = {bank_ff, cur_ff.operand};
    end else begin
      // Forced map needs no bank update first, so it fits one cycle
      direct_addr = access_map(cur_ff.operand, EXT_SET_EN, IDX_BASE);
    end
  end

  // Move carries both full addresses; the bank pointer plays no part
  assign rd_addr = is_move ? cur_ff.src : direct_addr;
  assign wr_addr = is_move ? cur_ff.dst : direct_addr;

  assign RD_ADDR = rd_addr;
  assign WR_ADDR = wr_addr;

  // ----------------------------------------------------------------
  // Read path: RAM sampled in Q2, result formed in Q3
  // ----------------------------------------------------------------

  logic              ram_rd_en;
  logic [DATA_W-1:0] ram_q;
  logic              ram_wr_en;
  logic [DATA_W-1:0] wr_byte;
  logic              wr_go;

  assign ram_rd_en = (phase_ff == Q2) && (is_direct || is_move);

  logic [DATA_W-1:0] rd_data_ff;
  logic              unimpl_ff;
  logic [DATA_W-1:0] rd_sel;

  always_comb begin
    if (rd_addr == BANK_PTR_ADDR) begin
      rd_sel = {BANK_PTR_HI, bank_ff};
    end else if (!implemented(rd_addr)) begin
      rd_sel = ZERO_BYTE;
    end else begin
      rd_sel = ram_q;
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rd_data_ff <= ZERO_BYTE;
    end else if (phase_ff == Q3 && (is_direct || is_move)) begin
      rd_data_ff <= rd_sel;
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      unimpl_ff <= 1'b0;
    end else if (phase_ff == Q2) begin
      unimpl_ff <= (is_direct || is_move) && !implemented(rd_addr);
    end
  end

  assign RD_DATA = rd_data_ff;
  assign UNIMPL  = unimpl_ff;

  // ----------------------------------------------------------------
  // Write path in Q4
  // ----------------------------------------------------------------

  assign wr_go   = (phase_ff == Q4) && ((is_direct && cur_ff.wr_en) || is_move);
  assign wr_byte = is_move ? rd_data_ff : cur_ff.wr_data;

  // Stores to missing banks are dropped; a direct store there still raises UNIMPL
  assign ram_wr_en = wr_go && implemented(wr_addr) && (wr_addr != BANK_PTR_ADDR);

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bank_ff <= BANK_PTR_RST;
    end else if (phase_ff == Q4 && is_load) begin
      bank_ff <= cur_ff.lit[BANK_W-1:0];
    end else if (wr_go && wr_addr == BANK_PTR_ADDR) begin
      // Upper nibble of the written byte is dropped
      bank_ff <= wr_byte[BANK_W-1:0];
    end
  end

  assign BANK_POINTER = {BANK_PTR_HI, bank_ff};

  logic              pcl_wr;
  logic [DATA_W-1:0] pcl_data_ff;

  // A stray banked store here redirects the program
  assign pcl_wr = wr_go && (wr_addr == PCL_ADDR);
  assign PCL_WR = pcl_wr;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pcl_data_ff <= ZERO_BYTE;
    end else if (pcl_wr) begin
      pcl_data_ff <= wr_byte;
    end
  end

  assign PCL_DATA = pcl_data_ff;

  // Flags follow every direct op, hit or miss
  assign FLAG_UPD = (phase_ff == Q4) && is_direct;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------

  dmem_ram u_ram (
    .clk     (MCLK),
    .rd_en   (ram_rd_en),
    .rd_addr (rd_addr),
    .rd_q    (ram_q),
    .wr_en   (ram_wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_byte)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  AST_PHASE_ORDER:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      phase_ff == Q1 |=> phase_ff == Q2 ##1 phase_ff == Q3 ##1 phase_ff == Q4 ##1 phase_ff == Q1)
    else $error("quarter phases out of order");

  AST_BANK_HI_ZERO:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      BANK_POINTER[DATA_W-1:BANK_W] == BANK_PTR_HI)
    else $error("bank pointer upper nibble not zero");

  AST_LOAD_BANK:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (phase_ff == Q4 && is_load) |=> bank_ff == $past(cur_ff.lit[BANK_W-1:0]))
    else $error("bank pointer not loaded from literal");

  AST_MOVE_FULL:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (phase_ff == Q2 && is_move) |-> RD_ADDR == cur_ff.src ##2 WR_ADDR == cur_ff.dst)
    else $error("move did not use its full addresses");

  AST_BANKED_ADDR:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (phase_ff == Q2 && is_direct && cur_ff.a_bit)
        |-> RD_ADDR == {BANK_POINTER[BANK_W-1:0], cur_ff.operand})
    else $error("banked address not bank plus operand");

  AST_ACCESS_LOW:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (phase_ff == Q2 && is_direct && !cur_ff.a_bit && !EXT_SET_EN && cur_ff.operand < ACC_SPLIT)
        |-> RD_ADDR[ADDR_W-1:OFS_W] == ACC_LO_BANK)
    else $error("low access offset not in bank 0");

  AST_ACCESS_HIGH:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (phase_ff == Q2 && is_direct && !cur_ff.a_bit && cur_ff.operand >= ACC_SPLIT)
        |-> RD_ADDR == {ACC_HI_BANK, cur_ff.operand})
    else $error("high access offset not in bank 15");

  AST_EXT_MAP:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (phase_ff == Q2 && is_direct && !cur_ff.a_bit && EXT_SET_EN && cur_ff.operand < ACC_SPLIT)
        |-> RD_ADDR == ADDR_W'(IDX_BASE + ADDR_W'(cur_ff.operand)))
    else $error("extended access map not applied");

  AST_UNIMPL_ZERO:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (phase_ff == Q3 && (is_direct || is_move) && !implemented(rd_addr)) |=> RD_DATA == ZERO_BYTE)
    else $error("unimplemented read not zero");

  AST_UNIMPL_NO_WR:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (wr_go && !implemented(wr_addr)) |-> !ram_wr_en)
    else $error("write reached unimplemented location");

  AST_FLAGS:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (phase_ff == Q2 && is_direct) |-> ##2 FLAG_UPD)
    else $error("flag update missing");

  AST_PCL_HIT:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (phase_ff == Q4 && is_direct && cur_ff.wr_en && cur_ff.a_bit
        && BANK_POINTER[BANK_W-1:0] == ACC_HI_BANK && cur_ff.operand == PCL_ADDR[OFS_W-1:0])
        |-> PCL_WR ##1 PCL_DATA == $past(cur_ff.wr_data))
    else $error("program counter low byte not written");

  AST_SINGLE_CYCLE:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (phase_ff == Q1 && INSTR_VALID && INSTR.kind == OP_DIRECT && !INSTR.a_bit)
        |=> ##2 (FLAG_UPD && phase_ff == Q4))
    else $error("forced access took more than one cycle");

  AST_SPECIAL_TOP:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (wr_go && wr_addr >= SPECIAL_BASE && wr_addr <= SPECIAL_TOP && wr_addr != BANK_PTR_ADDR) |-> ram_wr_en)
    else $error("special register write dropped");

  // Checked on the first edge after release, so no disable here
  AST_RESET_BANK:
    assert property (@(posedge MCLK)
      $fell(SYS_RST) |-> bank_ff == BANK_PTR_RST)
    else $error("bank pointer not zero after reset");

  AST_UNIMPL_FLAG:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (phase_ff == Q2 && (is_direct || is_move) && !implemented(rd_addr)) |=> UNIMPL)
    else $error("unimplemented flag missing");

  AST_UNIMPL_CLEAR:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (phase_ff == Q2 && (is_direct || is_move) && implemented(rd_addr)) |=> !UNIMPL)
    else $error("unimplemented flag on a real location");

  AST_BANK_WRITE:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (wr_go && wr_addr == BANK_PTR_ADDR) |=> bank_ff == $past(wr_byte[BANK_W-1:0]))
    else $error("bank pointer store lost");

  AST_BANK_READ:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (phase_ff == Q3 && (is_direct || is_move) && rd_addr == BANK_PTR_ADDR) |=> RD_DATA == BANK_POINTER)
    else $error("bank pointer read wrong");

  AST_BANK_QUIET:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      !(phase_ff == Q4 && (is_load || wr_go)) |=> bank_ff == $past(bank_ff))
    else $error("bank pointer changed outside a store");

  AST_ACCESS_NO_BANK:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (phase_ff == Q2 && is_direct && !cur_ff.a_bit && !EXT_SET_EN) |-> RD_ADDR[OFS_W-1:0] == cur_ff.operand)
    else $error("access map offset altered");

  AST_WRITE_Q4:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      ram_wr_en |-> phase_ff == Q4)
    else $error("data write outside Q4");

  AST_READ_Q2:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      ram_rd_en |-> phase_ff == Q2)
    else $error("data read outside Q2");

  AST_IDLE_QUIET:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (phase_ff == Q4 && !valid_ff) |-> !FLAG_UPD && !PCL_WR && !ram_wr_en)
    else $error("empty slot had an effect");

  AST_FLAG_ONLY_DIRECT:
    assert property (@(posedge MCLK) disable iff (SYS_RST)
      (phase_ff == Q4 && (is_move || is_load)) |-> !FLAG_UPD)
    else $error("flag update on move or bank load");

endmodule // banked_data_memory_addressing

`default_nettype wire

// ---- design/dmem_pkg.sv ----
// Constants, types and helpers for banked data-memory addressing.
// Assumes one core clock; the core presents each instruction at Q1.

`default_nettype none

package dmem_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int BANK_W = 4;
  localparam int OFS_W  = 8;
  localparam int MEM_BYTES = 4096;

  localparam logic [OFS_W-1:0]  ACC_SPLIT   = 8'h60;
  localparam logic [BANK_W-1:0] ACC_LO_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACC_HI_BANK = 4'hf;

  localparam logic [ADDR_W-1:0] SPECIAL_BASE  = 12'hf38;
  localparam logic [ADDR_W-1:0] SPECIAL_TOP   = 12'hfff;
  localparam logic [ADDR_W-1:0] GENERAL_TOP   = 12'h3ff;
  localparam logic [ADDR_W-1:0] BANK_PTR_ADDR = 12'hfe0;
  localparam logic [ADDR_W-1:0] PCL_ADDR      = 12'hff9;

  localparam logic [BANK_W-1:0] BANK_PTR_RST  = 4'h0;
  localparam logic [BANK_W-1:0] BANK_PTR_HI   = 4'h0;
  localparam logic [DATA_W-1:0] ZERO_BYTE     = 8'h00;

  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b11,
    Q4 = 2'b10
  } qphase_t;

  typedef enum logic [1:0] {
    OP_DIRECT    = 2'b00,
    OP_MOVE      = 2'b01,
    OP_LOAD_BANK = 2'b10,
    OP_NONE      = 2'b11
  } op_kind_t;

  typedef struct packed {
    op_kind_t          kind;
    logic              a_bit;
    logic [OFS_W-1:0]  operand;
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
    logic [DATA_W-1:0] lit;
    logic              wr_en;
    logic [DATA_W-1:0] wr_data;
  } instr_t;

  // General purpose banks at the bottom, special registers at the top
  function automatic logic implemented(input logic [ADDR_W-1:0] addr);
    return (addr <= GENERAL_TOP) || (addr >= SPECIAL_BASE);
  endfunction

  function automatic logic [ADDR_W-1:0] access_map(
    input logic [OFS_W-1:0]  ofs,
    input logic              ext,
    input logic [ADDR_W-1:0] idx_base
  );
    if (ofs >= ACC_SPLIT)
      return {ACC_HI_BANK, ofs};
    else if (ext)
      return ADDR_W'(idx_base + {{(ADDR_W-OFS_W){1'b0}}, ofs});
    else
      return {ACC_LO_BANK, ofs};
  endfunction

endpackage

`default_nettype wire

// ---- design/dmem_ram.sv ----
// Byte-wide static RAM covering the whole 12-bit data space.
// Assumes the caller gates writes to implemented locations.
`timescale 1ns/1ps
`default_nettype none

module dmem_ram
  import dmem_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_q,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data
);

  // Contents are not cleared by reset, like real register RAM
  logic [DATA_W-1:0] mem [MEM_BYTES];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_q <= mem[rd_addr];
    end
  end

endmodule // dmem_ram

`default_nettype wire
